// [design/bstp_boundary_scan_test_port.sv]
`timescale 1ns/1ps
`default_nettype none
module bstp_boundary_scan_test_port #(
  parameter int N_PINS = 4,
  parameter int IOSTD_W = 2,
  parameter int PROBE_W = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // test port pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo_r,
  output logic tdoOeN_r,
  // device pins
  input wire logic [N_PINS-1:0] pinIn,
  output logic [N_PINS-1:0] pinOut_r,
  output logic [N_PINS-1:0] pinOeN_r,
  // core side
  input wire logic [N_PINS-1:0] coreOut,
  input wire logic [N_PINS-1:0] coreOe,
  input wire logic configDone,
  input wire logic [PROBE_W-1:0] probe,
  output logic [N_PINS*IOSTD_W-1:0] ioStd_r,
  output logic cfgBit_r,
  output logic cfgStrobe_r
);
  localparam int BSR_LEN = N_PINS * bstp_pkg::CELL_W;
  localparam int IOS_LEN = N_PINS * IOSTD_W;
  localparam int M1 = (BSR_LEN > IOS_LEN) ? BSR_LEN : IOS_LEN;
  localparam int DRW = (M1 > PROBE_W) ? M1 : PROBE_W;
  localparam int SYW = bstp_pkg::SY_PINS + N_PINS;
  // ==========================================================
  // input synchroniser
  logic [SYW-1:0] syA_r, syB_r, syC_r, lvl_r, lvl_nxt;
  logic tckRise, tckFall, tmsL, tdiL;
  logic [N_PINS-1:0] pinL;

  always_comb begin
    // a change counts once second and third stages agree
    lvl_nxt = (syB_r & syC_r) | (lvl_r & (syB_r ^ syC_r));
    tckRise = lvl_nxt[bstp_pkg::SY_TCK] & ~lvl_r[bstp_pkg::SY_TCK];
    tckFall = ~lvl_nxt[bstp_pkg::SY_TCK] & lvl_r[bstp_pkg::SY_TCK];
    tmsL = lvl_nxt[bstp_pkg::SY_TMS];
    tdiL = lvl_nxt[bstp_pkg::SY_TDI];
    pinL = lvl_r[SYW-1:bstp_pkg::SY_PINS];
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      syA_r <= '0;
      syB_r <= '0;
      syC_r <= '0;
      lvl_r <= '0;
    end else begin
      syA_r <= {pinIn, tdi, tms, tck};
      syB_r <= syA_r;
      syC_r <= syB_r;
      lvl_r <= lvl_nxt;
    end
  end

  // ==========================================================
  // decode
  function automatic int unsigned dr_len(input logic [9:0] op);
    unique case (op)
      bstp_pkg::OP_EXTEST, bstp_pkg::OP_SAMPLE: dr_len = BSR_LEN;
      bstp_pkg::OP_CONFIG_IO: dr_len = IOS_LEN;
      bstp_pkg::OP_PROBE: dr_len = PROBE_W;
      default: dr_len = 1;
    endcase
  endfunction : dr_len

  function automatic logic is_op(input logic [9:0] op, input logic [9:0] code);
    is_op = (op == code);
  endfunction : is_op

  // ==========================================================
  // tap, instruction and data registers
  bstp_pkg::bstp_tap_t st_r, st_nxt;
  logic [9:0] irSh_r, irSh_nxt, instr_r, instr_nxt;
  logic [DRW-1:0] dr_r, dr_nxt;
  logic [BSR_LEN-1:0] upd_r, upd_nxt, capVec;
  logic [IOS_LEN-1:0] ioStd_nxt;
  logic cfgBit_nxt, cfgStrobe_nxt;
  int unsigned len;

  always_comb begin
    st_nxt = st_r;
    if (tckRise) begin
      unique case (st_r)
        bstp_pkg::TLR: st_nxt = tmsL ? bstp_pkg::TLR : bstp_pkg::RTI;
        bstp_pkg::RTI: st_nxt = tmsL ? bstp_pkg::SEL_DR : bstp_pkg::RTI;
        bstp_pkg::SEL_DR: st_nxt = tmsL ? bstp_pkg::SEL_IR : bstp_pkg::CAP_DR;
        bstp_pkg::CAP_DR: st_nxt = tmsL ? bstp_pkg::EX1_DR : bstp_pkg::SH_DR;
        bstp_pkg::SH_DR: st_nxt = tmsL ? bstp_pkg::EX1_DR : bstp_pkg::SH_DR;
        bstp_pkg::EX1_DR: st_nxt = tmsL ? bstp_pkg::UPD_DR : bstp_pkg::PA_DR;
        bstp_pkg::PA_DR: st_nxt = tmsL ? bstp_pkg::EX2_DR : bstp_pkg::PA_DR;
        bstp_pkg::EX2_DR: st_nxt = tmsL ? bstp_pkg::UPD_DR : bstp_pkg::SH_DR;
        bstp_pkg::UPD_DR: st_nxt = tmsL ? bstp_pkg::SEL_DR : bstp_pkg::RTI;
        bstp_pkg::SEL_IR: st_nxt = tmsL ? bstp_pkg::TLR : bstp_pkg::CAP_IR;
        bstp_pkg::CAP_IR: st_nxt = tmsL ? bstp_pkg::EX1_IR : bstp_pkg::SH_IR;
        bstp_pkg::SH_IR: st_nxt = tmsL ? bstp_pkg::EX1_IR : bstp_pkg::SH_IR;
        bstp_pkg::EX1_IR: st_nxt = tmsL ? bstp_pkg::UPD_IR : bstp_pkg::PA_IR;
        bstp_pkg::PA_IR: st_nxt = tmsL ? bstp_pkg::EX2_IR : bstp_pkg::PA_IR;
        bstp_pkg::EX2_IR: st_nxt = tmsL ? bstp_pkg::UPD_IR : bstp_pkg::SH_IR;
        bstp_pkg::UPD_IR: st_nxt = tmsL ? bstp_pkg::SEL_DR : bstp_pkg::RTI;
      endcase
    end
  end

  always_comb begin
    for (int i = 0; i < N_PINS; i++) begin
      capVec[i*bstp_pkg::CELL_W + bstp_pkg::CELL_IN] = pinL[i];
      capVec[i*bstp_pkg::CELL_W + bstp_pkg::CELL_OUT] = coreOut[i];
      capVec[i*bstp_pkg::CELL_W + bstp_pkg::CELL_EN] = coreOe[i];
    end
    len = dr_len(instr_r);
    irSh_nxt = irSh_r;
    instr_nxt = instr_r;
    dr_nxt = dr_r;
    upd_nxt = upd_r;
    ioStd_nxt = ioStd_r;
    cfgBit_nxt = cfgBit_r;
    cfgStrobe_nxt = 1'b0;
    if (tckRise) begin
      unique case (st_r)
        bstp_pkg::TLR: instr_nxt = bstp_pkg::IR_RESET;
        bstp_pkg::CAP_IR: irSh_nxt = bstp_pkg::IR_CAPTURE;
        bstp_pkg::SH_IR: irSh_nxt = {tdiL, irSh_r[9:1]};
        bstp_pkg::UPD_IR: instr_nxt = irSh_r;
        bstp_pkg::CAP_DR: begin
          dr_nxt = '0;
          if (is_op(instr_r, bstp_pkg::OP_SAMPLE) || is_op(instr_r, bstp_pkg::OP_EXTEST))
            dr_nxt[BSR_LEN-1:0] = capVec;
          if (is_op(instr_r, bstp_pkg::OP_PROBE))
            dr_nxt[PROBE_W-1:0] = probe;
          if (is_op(instr_r, bstp_pkg::OP_CONFIG_IO))
            dr_nxt[IOS_LEN-1:0] = ioStd_r;
        end
        bstp_pkg::SH_DR: begin
          // variable length chain, one stage for bypass
          for (int i = 0; i < DRW; i++)
            dr_nxt[i] = (i == len - 1) ? tdiL : ((i < DRW - 1) ? dr_r[i+1] : 1'b0);
          if (is_op(instr_r, bstp_pkg::OP_CFG_LOAD)) begin
            cfgBit_nxt = tdiL;
            cfgStrobe_nxt = 1'b1;
          end
        end
        bstp_pkg::UPD_DR: begin
          if (is_op(instr_r, bstp_pkg::OP_SAMPLE) || is_op(instr_r, bstp_pkg::OP_EXTEST))
            upd_nxt = dr_r[BSR_LEN-1:0];
          if (is_op(instr_r, bstp_pkg::OP_CONFIG_IO))
            ioStd_nxt = dr_r[IOS_LEN-1:0];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= bstp_pkg::TLR;
      irSh_r <= bstp_pkg::IR_CAPTURE;
      instr_r <= bstp_pkg::IR_RESET;
      dr_r <= '0;
      upd_r <= '0;
      ioStd_r <= '0;
      cfgBit_r <= 1'b0;
      cfgStrobe_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      irSh_r <= irSh_nxt;
      instr_r <= instr_nxt;
      dr_r <= dr_nxt;
      upd_r <= upd_nxt;
      ioStd_r <= ioStd_nxt;
      cfgBit_r <= cfgBit_nxt;
      cfgStrobe_r <= cfgStrobe_nxt;
    end
  end

  // ==========================================================
  // pins and serial out
  logic [N_PINS-1:0] extOut, extOeN, pinOut_nxt, pinOeN_nxt;
  logic tdo_nxt, tdoOeN_nxt, extest;

  always_comb begin
    extest = is_op(instr_r, bstp_pkg::OP_EXTEST);
    for (int i = 0; i < N_PINS; i++) begin
      extOut[i] = upd_r[i*bstp_pkg::CELL_W + bstp_pkg::CELL_OUT];
      extOeN[i] = ~upd_r[i*bstp_pkg::CELL_W + bstp_pkg::CELL_EN];
    end
    if (extest) begin
      pinOut_nxt = extOut;
      pinOeN_nxt = extOeN;
    end else if (!configDone) begin
      pinOut_nxt = '0;
      pinOeN_nxt = '1;
    end else begin
      pinOut_nxt = coreOut;
      pinOeN_nxt = ~coreOe;
    end
    // serial out changes on the falling test clock
    tdo_nxt = tdo_r;
    tdoOeN_nxt = tdoOeN_r;
    if (tckFall) begin
      tdo_nxt = (st_r == bstp_pkg::SH_IR) ? irSh_r[0] : dr_r[0];
      tdoOeN_nxt = !(st_r == bstp_pkg::SH_IR || st_r == bstp_pkg::SH_DR);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinOut_r <= '0;
      pinOeN_r <= '1;
      tdo_r <= 1'b0;
      tdoOeN_r <= 1'b1;
    end else begin
      pinOut_r <= pinOut_nxt;
      pinOeN_r <= pinOeN_nxt;
      tdo_r <= tdo_nxt;
      tdoOeN_r <= tdoOeN_nxt;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  property p_tlr_hold;
    tckRise && tmsL && st_r == bstp_pkg::TLR
      |=> st_r == bstp_pkg::TLR && instr_r == bstp_pkg::IR_RESET;
  endproperty
  a_tlr_hold: assert property (p_tlr_hold) else $error("tap left reset with tms high");

  property p_ir_update;
    tckRise && st_r == bstp_pkg::UPD_IR |=> instr_r == $past(irSh_r);
  endproperty
  a_ir_update: assert property (p_ir_update) else $error("instruction not updated");

  property p_ir_hold;
    !(tckRise && (st_r == bstp_pkg::UPD_IR || st_r == bstp_pkg::TLR)) |=> $stable(instr_r);
  endproperty
  a_ir_hold: assert property (p_ir_hold) else $error("instruction changed off update");

  property p_bypass;
    tckRise && st_r == bstp_pkg::SH_DR && dr_len(instr_r) == 1 |=> dr_r[0] == $past(tdiL);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass stage wrong");

  property p_extest;
    extest |=> pinOut_r == $past(extOut) && pinOeN_r == $past(extOeN);
  endproperty
  a_extest: assert property (p_extest) else $error("extest pattern not on pins");

  property p_powerup;
    !configDone && !extest |=> pinOeN_r == '1;
  endproperty
  a_powerup: assert property (p_powerup) else $error("pin driven before configured");

  property p_sample;
    tckRise && st_r == bstp_pkg::CAP_DR && instr_r == bstp_pkg::OP_SAMPLE
      |=> dr_r[BSR_LEN-1:0] == $past(capVec);
  endproperty
  a_sample: assert property (p_sample) else $error("sample capture wrong");

  property p_iostd;
    tckRise && st_r == bstp_pkg::UPD_DR && instr_r == bstp_pkg::OP_CONFIG_IO
      |=> ioStd_r == $past(dr_r[IOS_LEN-1:0]);
  endproperty
  a_iostd: assert property (p_iostd) else $error("io standard not rewritten");

  property p_cfg;
    tckRise && st_r == bstp_pkg::SH_DR && instr_r == bstp_pkg::OP_CFG_LOAD
      |=> cfgStrobe_r && cfgBit_r == $past(tdiL) ##1 !cfgStrobe_r;
  endproperty
  a_cfg: assert property (p_cfg) else $error("config bit not passed");

  property p_probe;
    tckRise && st_r == bstp_pkg::CAP_DR && instr_r == bstp_pkg::OP_PROBE
      |=> dr_r[PROBE_W-1:0] == $past(probe);
  endproperty
  a_probe: assert property (p_probe) else $error("probe not captured");
endmodule : bstp_boundary_scan_test_port
`default_nettype wire

// [dv/bstp_jtag_host.sv]
`timescale 1ns/1ps
`default_nettype none
module bstp_jtag_host (
  // clock
  input wire logic sys_clk,
  // test port
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdoOeN
);
  // ==========================================
  // test clock frames
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
  end
  // one test clock: 4 cycles low, 4 high; entered at a sys_clk edge
  task automatic step(input logic m, input logic d, output logic o);
    tck <= 1'h0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge sys_clk);
    tck <= 1'h1;
    repeat (4) @(posedge sys_clk);
    // sampled late in the high phase, clear of the tdo update
    // released line floats to its board pull-up
    o = tdoOeN ? 1'h1 : tdo;
  endtask : step
  task automatic reset_tap();
    logic o;
    repeat (5) step(1'h1, 1'h0, o);
    step(1'h0, 1'h0, o);
  endtask : reset_tap
  // bench orders boundary tests outside configuration
  task automatic scan(input logic ir, input logic [31:0] din, input int len,
                      output logic [31:0] dout);
    logic o;
    dout = 32'h0;
    step(1'h1, 1'h0, o);
    if (ir) step(1'h1, 1'h0, o);
    step(1'h0, 1'h0, o);
    step(1'h0, 1'h0, o);
    for (int i = 0; i < len; i++) begin
      step(i == len - 1, din[i], o);
      dout[i] = o;
    end
    step(1'h1, 1'h0, o);
    step(1'h0, 1'h0, o);
    // update lands four cycles after the rise, pins one cycle later
    repeat (2) @(posedge sys_clk);
  endtask : scan
endmodule : bstp_jtag_host
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk = 1'h0;
  logic reset_n = 1'h0;
  logic tck, tms, tdi, tdo, tdoOeN, configDone, cfgBit, cfgStrobe;
  logic [3:0] pinIn, pinOut, pinOeN, coreOut, coreOe;
  logic [7:0] probe, ioStd, cfgData;
  logic [31:0] o;
  int nFail = 0;
  int nTests = 0;
  int cfgCnt = 0;
  // ==========================================
  // clock, design and far side
  always #50 sys_clk = ~sys_clk;
  bstp_boundary_scan_test_port #(.N_PINS(4), .IOSTD_W(2), .PROBE_W(8)) i_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo_r(tdo), .tdoOeN_r(tdoOeN), .pinIn(pinIn), .pinOut_r(pinOut),
    .pinOeN_r(pinOeN), .coreOut(coreOut), .coreOe(coreOe),
    .configDone(configDone), .probe(probe), .ioStd_r(ioStd),
    .cfgBit_r(cfgBit), .cfgStrobe_r(cfgStrobe));
  bstp_jtag_host i_host (.sys_clk(sys_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdoOeN(tdoOeN));
  always @(posedge sys_clk) if (cfgStrobe) begin
    cfgData <= {cfgBit, cfgData[7:1]};
    cfgCnt <= cfgCnt + 1;
  end
  // ==========================================
  // helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      nFail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [11:0] cells(input logic [3:0] i, input logic [3:0] d,
                                        input logic [3:0] e);
    for (int k = 0; k < 4; k++) cells[3*k +: 3] = {e[k], d[k], i[k]};
  endfunction : cells
  task automatic load_ir(input logic [9:0] code);
    i_host.scan(1'h1, {22'h0, code}, 10, o);
    check("ir capture", o, 32'h001);
  endtask : load_ir
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  // ==========================================
  // scenarios
  task automatic t_reset();
    check("oe after reset", {tdoOeN, pinOeN}, 32'h1F);
    check("iostd after reset", ioStd, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_extest();
    pinIn <= 4'h9;
    load_ir(bstp_pkg::OP_SAMPLE);
    i_host.scan(1'h0, {20'h0, cells(4'h0, 4'h3, 4'hF)}, 12, o);
    check("pins after preload", {pinOut, pinOeN}, 32'hF);
    load_ir(bstp_pkg::OP_EXTEST);
    check("extest preload", {pinOut, pinOeN}, 32'h30);
    i_host.scan(1'h0, {20'h0, cells(4'h0, 4'hC, 4'h6)}, 12, o);
    check("extest capture", o & 32'h249, {20'h0, cells(4'h9, 4'h0, 4'h0)});
    check("extest drive", {pinOut, pinOeN}, 32'hC9);
    load_ir(bstp_pkg::OP_BYPASS);
    check("undriven unconfigured", pinOeN, 32'hF);
    $display("test extest done");
  endtask : t_extest
  task automatic t_cfgio();
    load_ir(bstp_pkg::OP_CONFIG_IO);
    i_host.scan(1'h0, 32'hC6, 8, o);
    check("iostd write", ioStd, 32'hC6);
    i_host.scan(1'h0, 32'h00, 8, o);
    check("iostd capture", o, 32'hC6);
    check("iostd clear", ioStd, 32'h0);
    $display("test config io done");
  endtask : t_cfgio
  task automatic t_cfgload();
    cfgCnt = 0;
    load_ir(bstp_pkg::OP_CFG_LOAD);
    i_host.scan(1'h0, 32'h9C, 8, o);
    check("config bits", cfgCnt, 32'h8);
    check("config data", cfgData, 32'h9C);
    $display("test config load done");
  endtask : t_cfgload
  task automatic t_sample();
    configDone <= 1'h1;
    coreOut <= 4'hA;
    coreOe <= 4'h5;
    pinIn <= 4'h6;
    load_ir(bstp_pkg::OP_SAMPLE);
    i_host.scan(1'h0, 32'h0, 12, o);
    check("sample capture", o, {20'h0, cells(4'h6, 4'hA, 4'h5)});
    check("sample no disturb", {pinOut, pinOeN}, 32'hAA);
    $display("test sample done");
  endtask : t_sample
  task automatic t_bypass();
    coreOut <= 4'h9;
    coreOe <= 4'h3;
    for (int i = 0; i < 3; i++) begin
      if (i == 0) load_ir(bstp_pkg::OP_BYPASS);
      else if (i == 1) load_ir(10'h0AB);
      else begin
        load_ir(bstp_pkg::OP_CONFIG_IO);
        i_host.reset_tap();
      end
      i_host.scan(1'h0, 32'hB5, 8, o);
      check("bypass delay", o, 32'h6A);
      check("bypass pins", {pinOut, pinOeN}, 32'h9C);
    end
    $display("test bypass done");
  endtask : t_bypass
  task automatic t_probe();
    probe <= 8'h5A;
    load_ir(bstp_pkg::OP_PROBE);
    i_host.scan(1'h0, 32'h0, 8, o);
    check("probe readout", o, 32'h5A);
    $display("test probe done");
  endtask : t_probe
  // ==========================================
  // main sequence and watchdog
  initial begin
    {pinIn, coreOut, coreOe, configDone, probe} <= '0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'h1;
    @(posedge sys_clk);
    t_reset();
    i_host.reset_tap();
    t_extest();
    t_cfgio();
    t_cfgload();
    t_sample();
    t_bypass();
    t_probe();
    complete_run();
  end
  initial begin
    // about 20 scans of some 15 test clocks each, with wide margin
    repeat (30000) @(posedge sys_clk);
    nFail++;
    $display("[FAIL] watchdog expected finish seen hang");
    complete_run();
  end
endmodule : tb
`default_nettype wire

// [include/bstp_pkg.sv]
// Function
// - TAP state sequencing and instruction handling follow the standard test port.
// - Configuration data is accepted serially through the test port.
// - Pin I/O standard settings can be rewritten through the scan chain anytime.
// - Code 005 snapshots pins into boundary register and preloads a pattern.
// - Code 000 drives boundary pattern onto pins and captures input pins.
// - Code 3FF places one-stage bypass between data in and data out.
// - Pins stay undriven until configuration completes, except under code 000.
// - Test port reads out internally captured probe activity.
// - Instruction register is ten bits; every instruction is ten bits.
`default_nettype none
package bstp_pkg;
  // ==========================================================
  // instruction register
  localparam int IR_LEN = 10;
  localparam logic [9:0] IR_CAPTURE = 10'h001;
  localparam logic [9:0] OP_EXTEST = 10'h000;
  localparam logic [9:0] OP_SAMPLE = 10'h005;
  localparam logic [9:0] OP_BYPASS = 10'h3FF;
  localparam logic [9:0] OP_CONFIG_IO = 10'h00D;
  localparam logic [9:0] OP_CFG_LOAD = 10'h002;
  localparam logic [9:0] OP_PROBE = 10'h00E;
  localparam logic [9:0] IR_RESET = OP_BYPASS;
  // ==========================================================
  // boundary cell layout, three bits per pin
  localparam int CELL_W = 3;
  localparam int CELL_IN = 0;
  localparam int CELL_OUT = 1;
  localparam int CELL_EN = 2;
  // ==========================================================
  // synchroniser bit positions
  localparam int SY_TCK = 0;
  localparam int SY_TMS = 1;
  localparam int SY_TDI = 2;
  localparam int SY_PINS = 3;
  // ==========================================================
  // tap controller
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } bstp_tap_t;
endpackage : bstp_pkg
`default_nettype wire
